// File: design/iop_io_port_bank.sv
// io port bank: seven memory-mapped pin latch ports with apb access and pin edge interrupts
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// - latches mapped at FF0H to FF6H, bank 15
// - each port address reads, writes, tests latches; ext irq and analog ports ignore writes
// - 24 pins: 6 input, 18 configurable
// - serial and timer ports are three bits
// - per-pin pull-ups removed on output pins
// - each bidirectional pin individually input or output
// - ext irq port two-bit input, pull-ups
// - analog port four-bit input, comparator shared
// - wide ports 4 or 8-bit access
// - wide port pull-up per port, inputs only
// - wide port per-pin open-drain or push-pull
// - key and tone port four bits wide
// - first irq pin detects both edges
// - second irq pin detects selected edge
// - key scan falling edge raises quasi irq
module iop_io_port_bank
   import iop_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [IOP_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [IOP_W3-1:0] serial_pin_port_in,
   output logic [IOP_W3-1:0] serial_pin_port_out,
   output logic [IOP_W3-1:0] serial_pin_port_oe,
   output logic [IOP_W3-1:0] serial_pin_port_pu,
   input wire logic [IOP_W2-1:0] ext_irq_port_in,
   output logic [IOP_W2-1:0] ext_irq_port_pu,
   input wire logic [IOP_W4-1:0] analog_in_port_in,
   output logic [IOP_W4-1:0] comparator_inputs,
   input wire logic [IOP_W3-1:0] timer_pin_port_in,
   output logic [IOP_W3-1:0] timer_pin_port_out,
   output logic [IOP_W3-1:0] timer_pin_port_oe,
   output logic [IOP_W3-1:0] timer_pin_port_pu,
   input wire logic [IOP_W8-1:0] wide_port_in,
   output logic [IOP_W8-1:0] wide_port_out,
   output logic [IOP_W8-1:0] wide_port_oe,
   output logic [IOP_W8-1:0] wide_port_pu,
   input wire logic [IOP_W4-1:0] key_tone_port_in,
   output logic [IOP_W4-1:0] key_tone_port_out,
   output logic [IOP_W4-1:0] key_tone_port_oe,
   output logic [IOP_W4-1:0] key_tone_port_pu,
   output logic ext_irq_a,
   output logic ext_irq_b,
   output logic key_edge_quasi_irq,
   output logic irq
);

   // two-stage synchronisers for every pin input; 24 pins in total
   localparam int PIN_W = IOP_W3 + IOP_W2 + IOP_W4 + IOP_W3 + IOP_W8 + IOP_W4;
   logic [PIN_W-1:0] sync1_reg, sync2_reg, pin_prev_reg;
   logic [PIN_W-1:0] pins_raw;
   logic [IOP_W3-1:0] ser_s, tmr_s;
   logic [IOP_W2-1:0] ext_s, ext_p;
   logic [IOP_W4-1:0] ana_s, key_s, key_p;
   logic [IOP_W8-1:0] wide_s;

   assign pins_raw = {key_tone_port_in, wide_port_in, timer_pin_port_in, analog_in_port_in,
                      ext_irq_port_in, serial_pin_port_in};
   assign {key_s, wide_s, tmr_s, ana_s, ext_s, ser_s} = sync2_reg;
   assign ext_p = pin_prev_reg[IOP_W3+IOP_W2-1:IOP_W3];
   assign key_p = pin_prev_reg[PIN_W-1:PIN_W-IOP_W4];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         pin_prev_reg <= '0;
      end else begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
         pin_prev_reg <= sync2_reg;
      end
   end

   // software state
   logic [IOP_W3-1:0] ser_lat_reg, ser_lat_next, tmr_lat_reg, tmr_lat_next;
   logic [IOP_W3-1:0] ser_dir_reg, ser_dir_next, tmr_dir_reg, tmr_dir_next;
   logic [IOP_W3-1:0] ser_pu_reg, ser_pu_next, tmr_pu_reg, tmr_pu_next;
   logic [IOP_W8-1:0] wide_lat_reg, wide_lat_next, wide_dir_reg, wide_dir_next;
   logic [IOP_W8-1:0] wide_od_reg, wide_od_next;
   logic [1:0] wide_pu_reg, wide_pu_next;
   logic [IOP_W4-1:0] key_lat_reg, key_lat_next, key_dir_reg, key_dir_next;
   logic [IOP_W4-1:0] key_pu_reg, key_pu_next;
   logic [IOP_W2-1:0] ext_pu_reg, ext_pu_next;
   logic edge_sel_reg, edge_sel_next;
   logic [IOP_IRQ_W-1:0] stat_reg, stat_next, en_reg, en_next;
   logic [31:0] prdata_next;
   logic pslverr_next, pready_next;
   logic [IOP_IRQ_W-1:0] events;
   logic wr_en, rd_en;

   // pin value seen by software: latch for outputs, synchronised pin for inputs
   function automatic logic [7:0] pin_view(input logic [7:0] lat, input logic [7:0] dir,
                                           input logic [7:0] pin);
      pin_view = (lat & dir) | (pin & ~dir);
   endfunction

   // both edges on first pin, selected edge on second, falling on any key scan line
   assign events[IOP_IRQ_BIT_A] = ext_s[0] ^ ext_p[0];
   assign events[IOP_IRQ_BIT_B] = (edge_sel_reg == IOP_EDGE_RISE) ? (ext_s[1] & ~ext_p[1]) :
                                  (~ext_s[1] & ext_p[1]);
   assign events[IOP_IRQ_BIT_KEY] = |(key_p[IOP_KEY_SCAN_W-1:0] & ~key_s[IOP_KEY_SCAN_W-1:0]);

   // one-cycle access phase: answered on the first penable cycle
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;

   always_comb begin
      ser_lat_next = ser_lat_reg;
      tmr_lat_next = tmr_lat_reg;
      ser_dir_next = ser_dir_reg;
      tmr_dir_next = tmr_dir_reg;
      ser_pu_next = ser_pu_reg;
      tmr_pu_next = tmr_pu_reg;
      wide_lat_next = wide_lat_reg;
      wide_dir_next = wide_dir_reg;
      wide_od_next = wide_od_reg;
      wide_pu_next = wide_pu_reg;
      key_lat_next = key_lat_reg;
      key_dir_next = key_dir_reg;
      key_pu_next = key_pu_reg;
      ext_pu_next = ext_pu_reg;
      edge_sel_next = edge_sel_reg;
      en_next = en_reg;
      stat_next = stat_reg;
      if (wr_en) begin
         case (paddr)
            IOP_ADDR_SERIAL: ser_lat_next = pwdata[IOP_W3-1:0];
            IOP_ADDR_TIMER: tmr_lat_next = pwdata[IOP_W3-1:0];
            IOP_ADDR_WIDE_A: wide_lat_next[IOP_W4-1:0] = pwdata[IOP_W4-1:0];
            IOP_ADDR_WIDE_B: wide_lat_next[IOP_W8-1:IOP_W4] = pwdata[IOP_W4-1:0];
            IOP_ADDR_WIDE_AB: wide_lat_next = pwdata[IOP_W8-1:0];
            IOP_ADDR_KEY: key_lat_next = pwdata[IOP_W4-1:0];
            IOP_ADDR_DIR_SER: ser_dir_next = pwdata[IOP_W3-1:0];
            IOP_ADDR_DIR_TMR: tmr_dir_next = pwdata[IOP_W3-1:0];
            IOP_ADDR_DIR_WIDE: wide_dir_next = pwdata[IOP_W8-1:0];
            IOP_ADDR_DIR_KEY: key_dir_next = pwdata[IOP_W4-1:0];
            IOP_ADDR_PU_SER: ser_pu_next = pwdata[IOP_W3-1:0];
            IOP_ADDR_PU_TMR: tmr_pu_next = pwdata[IOP_W3-1:0];
            IOP_ADDR_PU_KEY: key_pu_next = pwdata[IOP_W4-1:0];
            IOP_ADDR_PU_EXT: ext_pu_next = pwdata[IOP_W2-1:0];
            IOP_ADDR_PU_WIDE: wide_pu_next = pwdata[1:0];
            IOP_ADDR_OD_WIDE: wide_od_next = pwdata[IOP_W8-1:0];
            IOP_ADDR_EDGE_SEL: edge_sel_next = pwdata[0];
            IOP_ADDR_IRQ_EN: en_next = pwdata[IOP_IRQ_W-1:0];
            IOP_ADDR_IRQ_CLR: stat_next = stat_reg & ~pwdata[IOP_IRQ_W-1:0];
            // input-only ports and status ignore writes without error
            IOP_ADDR_EXTIRQ, IOP_ADDR_ANALOG, IOP_ADDR_IRQ_STAT: ;
            default: ;
         endcase
      end
      // a new event wins over a clear in the same cycle
      stat_next = stat_next | events;
   end

   // read mux, registered at the setup cycle so prdata is valid in the access phase
   always_comb begin
      prdata_next = prdata;
      pslverr_next = 1'b0;
      pready_next = 1'b0;
      if (psel & ~penable) begin
         pready_next = 1'b1;
         if (rd_en) begin
            prdata_next = '0;
            case (paddr)
               IOP_ADDR_SERIAL: prdata_next[IOP_W3-1:0] = 3'(pin_view({5'h00, ser_lat_reg},
                                {5'h00, ser_dir_reg}, {5'h00, ser_s}));
               IOP_ADDR_EXTIRQ: prdata_next[IOP_W2-1:0] = ext_s;
               IOP_ADDR_ANALOG: prdata_next[IOP_W4-1:0] = ana_s;
               IOP_ADDR_TIMER: prdata_next[IOP_W3-1:0] = 3'(pin_view({5'h00, tmr_lat_reg},
                               {5'h00, tmr_dir_reg}, {5'h00, tmr_s}));
               IOP_ADDR_WIDE_A: prdata_next[IOP_W4-1:0] =
                  4'(pin_view(wide_lat_reg, wide_dir_reg, wide_s));
               IOP_ADDR_WIDE_B: prdata_next[IOP_W4-1:0] =
                  4'(pin_view(wide_lat_reg, wide_dir_reg, wide_s) >> IOP_W4);
               IOP_ADDR_WIDE_AB: prdata_next[IOP_W8-1:0] =
                  pin_view(wide_lat_reg, wide_dir_reg, wide_s);
               IOP_ADDR_KEY: prdata_next[IOP_W4-1:0] = 4'(pin_view({4'h0, key_lat_reg},
                             {4'h0, key_dir_reg}, {4'h0, key_s}));
               IOP_ADDR_DIR_SER: prdata_next[IOP_W3-1:0] = ser_dir_reg;
               IOP_ADDR_DIR_TMR: prdata_next[IOP_W3-1:0] = tmr_dir_reg;
               IOP_ADDR_DIR_WIDE: prdata_next[IOP_W8-1:0] = wide_dir_reg;
               IOP_ADDR_DIR_KEY: prdata_next[IOP_W4-1:0] = key_dir_reg;
               IOP_ADDR_PU_SER: prdata_next[IOP_W3-1:0] = ser_pu_reg;
               IOP_ADDR_PU_TMR: prdata_next[IOP_W3-1:0] = tmr_pu_reg;
               IOP_ADDR_PU_KEY: prdata_next[IOP_W4-1:0] = key_pu_reg;
               IOP_ADDR_PU_EXT: prdata_next[IOP_W2-1:0] = ext_pu_reg;
               IOP_ADDR_PU_WIDE: prdata_next[1:0] = wide_pu_reg;
               IOP_ADDR_OD_WIDE: prdata_next[IOP_W8-1:0] = wide_od_reg;
               IOP_ADDR_EDGE_SEL: prdata_next[0] = edge_sel_reg;
               IOP_ADDR_IRQ_STAT: prdata_next[IOP_IRQ_W-1:0] = stat_reg;
               IOP_ADDR_IRQ_EN: prdata_next[IOP_IRQ_W-1:0] = en_reg;
               IOP_ADDR_IRQ_CLR: prdata_next = '0;
               default: pslverr_next = 1'b1;
            endcase
         end else begin
            case (paddr)
               IOP_ADDR_SERIAL, IOP_ADDR_EXTIRQ, IOP_ADDR_ANALOG, IOP_ADDR_TIMER, IOP_ADDR_WIDE_A,
               IOP_ADDR_WIDE_B, IOP_ADDR_WIDE_AB, IOP_ADDR_KEY, IOP_ADDR_DIR_SER, IOP_ADDR_DIR_TMR,
               IOP_ADDR_DIR_WIDE, IOP_ADDR_DIR_KEY, IOP_ADDR_PU_SER, IOP_ADDR_PU_TMR, IOP_ADDR_PU_KEY,
               IOP_ADDR_PU_EXT, IOP_ADDR_PU_WIDE, IOP_ADDR_OD_WIDE, IOP_ADDR_EDGE_SEL, IOP_ADDR_IRQ_STAT,
               IOP_ADDR_IRQ_EN, IOP_ADDR_IRQ_CLR: pslverr_next = 1'b0;
               default: pslverr_next = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ser_lat_reg <= '0;
         tmr_lat_reg <= '0;
         ser_dir_reg <= '0;
         tmr_dir_reg <= '0;
         ser_pu_reg <= '0;
         tmr_pu_reg <= '0;
         wide_lat_reg <= IOP_RST_ZERO;
         wide_dir_reg <= IOP_RST_ZERO;
         wide_od_reg <= IOP_RST_ZERO;
         wide_pu_reg <= '0;
         key_lat_reg <= '0;
         key_dir_reg <= '0;
         key_pu_reg <= '0;
         ext_pu_reg <= '0;
         edge_sel_reg <= IOP_EDGE_RISE;
         stat_reg <= '0;
         en_reg <= '0;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ser_lat_reg <= ser_lat_next;
         tmr_lat_reg <= tmr_lat_next;
         ser_dir_reg <= ser_dir_next;
         tmr_dir_reg <= tmr_dir_next;
         ser_pu_reg <= ser_pu_next;
         tmr_pu_reg <= tmr_pu_next;
         wide_lat_reg <= wide_lat_next;
         wide_dir_reg <= wide_dir_next;
         wide_od_reg <= wide_od_next;
         wide_pu_reg <= wide_pu_next;
         key_lat_reg <= key_lat_next;
         key_dir_reg <= key_dir_next;
         key_pu_reg <= key_pu_next;
         ext_pu_reg <= ext_pu_next;
         edge_sel_reg <= edge_sel_next;
         stat_reg <= stat_next;
         en_reg <= en_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
      end
   end

   // pin drive, registered so every output comes from a flip-flop
   logic [IOP_W8-1:0] wide_pu_exp;
   assign wide_pu_exp = {{IOP_W4{wide_pu_reg[IOP_PU_WIDE_B_BIT]}}, {IOP_W4{wide_pu_reg[IOP_PU_WIDE_A_BIT]}}};
   logic [IOP_W3-1:0] ser_o_next, ser_oe_next, ser_pp_next, tmr_o_next, tmr_oe_next, tmr_pp_next;
   logic [IOP_W8-1:0] wide_o_next, wide_oe_next, wide_pp_next;
   logic [IOP_W4-1:0] key_o_next, key_oe_next, key_pp_next, cmp_next;
   logic [IOP_W2-1:0] ext_pp_next;
   logic irq_a_next, irq_b_next, irq_k_next, irq_next;

   always_comb begin
      ser_o_next = ser_lat_reg;
      ser_oe_next = ser_dir_reg;
      ser_pp_next = ser_pu_reg & ~ser_dir_reg;
      tmr_o_next = tmr_lat_reg;
      tmr_oe_next = tmr_dir_reg;
      tmr_pp_next = tmr_pu_reg & ~tmr_dir_reg;
      wide_o_next = wide_lat_reg;
      // open-drain pins only drive low, releasing the pin for a one
      wide_oe_next = wide_dir_reg & ~(wide_od_reg & wide_lat_reg);
      wide_pp_next = wide_pu_exp & ~wide_dir_reg;
      key_o_next = key_lat_reg;
      key_oe_next = key_dir_reg;
      key_pp_next = key_pu_reg & ~key_dir_reg;
      ext_pp_next = ext_pu_reg;
      cmp_next = ana_s;
      irq_a_next = events[IOP_IRQ_BIT_A];
      irq_b_next = events[IOP_IRQ_BIT_B];
      irq_k_next = events[IOP_IRQ_BIT_KEY];
      irq_next = |(stat_next & en_next);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_pin_port_out <= '0;
         serial_pin_port_oe <= '0;
         serial_pin_port_pu <= '0;
         timer_pin_port_out <= '0;
         timer_pin_port_oe <= '0;
         timer_pin_port_pu <= '0;
         wide_port_out <= '0;
         wide_port_oe <= '0;
         wide_port_pu <= '0;
         key_tone_port_out <= '0;
         key_tone_port_oe <= '0;
         key_tone_port_pu <= '0;
         ext_irq_port_pu <= '0;
         comparator_inputs <= '0;
         ext_irq_a <= 1'b0;
         ext_irq_b <= 1'b0;
         key_edge_quasi_irq <= 1'b0;
         irq <= 1'b0;
      end else begin
         serial_pin_port_out <= ser_o_next;
         serial_pin_port_oe <= ser_oe_next;
         serial_pin_port_pu <= ser_pp_next;
         timer_pin_port_out <= tmr_o_next;
         timer_pin_port_oe <= tmr_oe_next;
         timer_pin_port_pu <= tmr_pp_next;
         wide_port_out <= wide_o_next;
         wide_port_oe <= wide_oe_next;
         wide_port_pu <= wide_pp_next;
         key_tone_port_out <= key_o_next;
         key_tone_port_oe <= key_oe_next;
         key_tone_port_pu <= key_pp_next;
         ext_irq_port_pu <= ext_pp_next;
         comparator_inputs <= cmp_next;
         ext_irq_a <= irq_a_next;
         ext_irq_b <= irq_b_next;
         key_edge_quasi_irq <= irq_k_next;
         irq <= irq_next;
      end
   end

endmodule

// File: design/iop_pkg.sv
// package for the io port bank: register map, field layouts, reset values
package iop_pkg;
   // port latch locations, data memory bank 15 (index = low byte of FF0H..FF6H)
   localparam logic [3:0] IOP_IO_BANK = 4'hF;
   localparam logic [7:0] IOP_IDX_SERIAL = 8'hF0;
   localparam logic [7:0] IOP_IDX_EXTIRQ = 8'hF1;
   localparam logic [7:0] IOP_IDX_ANALOG = 8'hF2;
   localparam logic [7:0] IOP_IDX_TIMER = 8'hF3;
   localparam logic [7:0] IOP_IDX_WIDE_A = 8'hF4;
   localparam logic [7:0] IOP_IDX_WIDE_B = 8'hF5;
   localparam logic [7:0] IOP_IDX_KEY = 8'hF6;
   // byte addresses on apb: index times four (F1H..F3H, F5H and F6H are not multiples of four)
   localparam logic [11:0] IOP_ADDR_SERIAL = 12'h3C0;
   localparam logic [11:0] IOP_ADDR_EXTIRQ = 12'h3C4;
   localparam logic [11:0] IOP_ADDR_ANALOG = 12'h3C8;
   localparam logic [11:0] IOP_ADDR_TIMER = 12'h3CC;
   localparam logic [11:0] IOP_ADDR_WIDE_A = 12'h3D0;
   localparam logic [11:0] IOP_ADDR_WIDE_B = 12'h3D4;
   localparam logic [11:0] IOP_ADDR_KEY = 12'h3D8;
   // 8-bit wide port access, configuration and interrupt registers
   localparam logic [11:0] IOP_ADDR_WIDE_AB = 12'h400;
   localparam logic [11:0] IOP_ADDR_DIR_SER = 12'h404;
   localparam logic [11:0] IOP_ADDR_DIR_TMR = 12'h408;
   localparam logic [11:0] IOP_ADDR_DIR_WIDE = 12'h40C;
   localparam logic [11:0] IOP_ADDR_DIR_KEY = 12'h410;
   localparam logic [11:0] IOP_ADDR_PU_SER = 12'h414;
   localparam logic [11:0] IOP_ADDR_PU_TMR = 12'h418;
   localparam logic [11:0] IOP_ADDR_PU_KEY = 12'h41C;
   localparam logic [11:0] IOP_ADDR_PU_EXT = 12'h420;
   localparam logic [11:0] IOP_ADDR_PU_WIDE = 12'h424;
   localparam logic [11:0] IOP_ADDR_OD_WIDE = 12'h428;
   localparam logic [11:0] IOP_ADDR_EDGE_SEL = 12'h42C;
   localparam logic [11:0] IOP_ADDR_IRQ_STAT = 12'h430;
   localparam logic [11:0] IOP_ADDR_IRQ_EN = 12'h434;
   localparam logic [11:0] IOP_ADDR_IRQ_CLR = 12'h438;
   localparam int IOP_ADDR_W = 12;
   // field layouts
   localparam int IOP_W3 = 3;
   localparam int IOP_W2 = 2;
   localparam int IOP_W4 = 4;
   localparam int IOP_W8 = 8;
   localparam int IOP_IRQ_BIT_A = 0;
   localparam int IOP_IRQ_BIT_B = 1;
   localparam int IOP_IRQ_BIT_KEY = 2;
   localparam int IOP_IRQ_W = 3;
   localparam int IOP_PU_WIDE_A_BIT = 0;
   localparam int IOP_PU_WIDE_B_BIT = 1;
   localparam int IOP_KEY_SCAN_W = 3;
   // reset values: inputs, no pull-ups, push-pull, rising edge on second irq pin
   localparam logic [7:0] IOP_RST_ZERO = 8'h00;
   localparam logic IOP_EDGE_RISE = 1'b0;
endpackage

// File: verification/iop_io_port_bank_monitor.sv
// checker for the io port bank: apb timing, pull-up masking, pin edge events
`timescale 1ns/10ps
module iop_io_port_bank_monitor
   import iop_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [IOP_W3-1:0] serial_pin_port_oe,
   input wire logic [IOP_W3-1:0] serial_pin_port_pu,
   input wire logic [IOP_W3-1:0] timer_pin_port_oe,
   input wire logic [IOP_W3-1:0] timer_pin_port_pu,
   input wire logic [IOP_W4-1:0] key_tone_port_in,
   input wire logic [IOP_W4-1:0] key_tone_port_oe,
   input wire logic [IOP_W4-1:0] key_tone_port_pu,
   input wire logic [IOP_W8-1:0] wide_port_oe,
   input wire logic [IOP_W8-1:0] wide_port_pu,
   input wire logic [IOP_W2-1:0] ext_irq_port_in,
   input wire logic [IOP_W4-1:0] analog_in_port_in,
   input wire logic [IOP_W4-1:0] comparator_inputs,
   input wire logic ext_irq_a,
   input wire logic key_edge_quasi_irq,
   input wire logic irq
);
   logic apb_wr;
   assign apb_wr = psel && penable && pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access; psel && penable; endsequence
   property p_ready; s_access |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready missing in access phase");
   property p_ready_once; pready |=> !pready; endproperty
   a_ready_once: assert property (p_ready_once) else $error("pready longer than one cycle");
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("error answer malformed");
   property p_rst; $rose(presetn) |-> (serial_pin_port_oe | timer_pin_port_oe | key_tone_port_oe) == 4'h0
      && wide_port_oe == 8'h00 && !irq; endproperty
   a_rst: assert property (p_rst) else $error("pin driven right after reset");
   property p_pu_out; ((serial_pin_port_pu & serial_pin_port_oe) | (timer_pin_port_pu & timer_pin_port_oe)
      | (key_tone_port_pu & key_tone_port_oe)) == 4'h0; endproperty
   a_pu_out: assert property (p_pu_out) else $error("pull-up on driven pin");
   property p_pu_wide; (wide_port_pu & wide_port_oe) == 8'h00; endproperty
   a_pu_wide: assert property (p_pu_wide) else $error("wide pull-up on driven pin");
   property p_edge_a; $changed(ext_irq_port_in[0]) |-> ##[1:5] ext_irq_a; endproperty
   a_edge_a: assert property (p_edge_a) else $error("first irq pin edge missed");
   property p_key; $fell(key_tone_port_in[0]) |-> ##[1:5] key_edge_quasi_irq; endproperty
   a_key: assert property (p_key) else $error("key falling edge missed");
   property p_irq_fall; $fell(irq) |-> $past(apb_wr, 1) || $past(apb_wr, 2); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without a write");
   property p_cmp; $stable(analog_in_port_in)[*4] |-> comparator_inputs == analog_in_port_in; endproperty
   a_cmp: assert property (p_cmp) else $error("comparator inputs stale");
endmodule
bind iop_io_port_bank iop_io_port_bank_monitor iop_io_port_bank_monitor_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_pin_port_oe(serial_pin_port_oe), .serial_pin_port_pu(serial_pin_port_pu),
   .timer_pin_port_oe(timer_pin_port_oe), .timer_pin_port_pu(timer_pin_port_pu),
   .key_tone_port_in(key_tone_port_in), .key_tone_port_oe(key_tone_port_oe), .key_tone_port_pu(key_tone_port_pu),
   .wide_port_oe(wide_port_oe), .wide_port_pu(wide_port_pu), .ext_irq_port_in(ext_irq_port_in),
   .analog_in_port_in(analog_in_port_in), .comparator_inputs(comparator_inputs), .ext_irq_a(ext_irq_a),
   .key_edge_quasi_irq(key_edge_quasi_irq), .irq(irq));

// File: verification/iop_pin_model.sv
// model of the circuitry on a group of port pins
`timescale 1ns/10ps
module iop_pin_model #(
   parameter int W = 4
) (
   input wire logic pclk,
   input wire logic [W-1:0] dev_out,
   input wire logic [W-1:0] dev_oe,
   input wire logic [W-1:0] dev_pu,
   input wire logic [W-1:0] ext_val,
   input wire logic [W-1:0] ext_en,
   output logic [W-1:0] pin
);
   logic [W-1:0] wander = '0;
   // a floating pin keeps changing so a stale level never reads back as valid
   always @(posedge pclk) wander <= ~wander;
   // external drive sits behind a series resistor, so the device wins any contention
   assign pin = (dev_oe & dev_out) | (~dev_oe & ext_en & ext_val) | (~dev_oe & ~ext_en & (dev_pu | wander));
endmodule

// File: verification/tb_io_port_bank.sv
// self-checking bench for the io port bank
`timescale 1ns/10ps
module tb_io_port_bank
   import iop_pkg::*;
   ;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, d, v, e, m, od, x;
   logic pready, pslverr, err, ia, ib, ik, irq;
   logic [2:0] so, soe, spu, sp, se = 3'h0, to, toe, tpu, tp, te = 3'h0;
   logic [7:0] wo, woe, wpu, wp, we = 8'h00, xen = 8'hFF;
   logic [3:0] ko, koe, kpu, kp, ke = 4'hF, ana = 4'h0, cmp, po, poe, ppu;
   logic [1:0] xi = 2'h0, xpu;
   integer seed = 74175, err_count = 0, num_checks = 0, cyc = 0, nb = 0, i, j;
   logic [11:0] pa [3] = '{IOP_ADDR_SERIAL, IOP_ADDR_TIMER, IOP_ADDR_KEY};
   logic [11:0] da [3] = '{IOP_ADDR_DIR_SER, IOP_ADDR_DIR_TMR, IOP_ADDR_DIR_KEY};
   logic [11:0] ua [3] = '{IOP_ADDR_PU_SER, IOP_ADDR_PU_TMR, IOP_ADDR_PU_KEY};
   // {edge select, irq pins, key line 0, expected status}
   logic [6:0] tab [8] = '{7'h19, 7'h09, 7'h2A, 7'h08, 7'h68, 7'h4A, 7'h44, 7'h08};
   always #20 pclk = ~pclk;
   iop_pin_model #(.W(3)) ser_pins (.pclk(pclk), .dev_out(so), .dev_oe(soe), .dev_pu(spu), .ext_val(se),
      .ext_en(xen[2:0]), .pin(sp));
   iop_pin_model #(.W(3)) tmr_pins (.pclk(pclk), .dev_out(to), .dev_oe(toe), .dev_pu(tpu), .ext_val(te),
      .ext_en(xen[2:0]), .pin(tp));
   iop_pin_model #(.W(8)) wide_pins (.pclk(pclk), .dev_out(wo), .dev_oe(woe), .dev_pu(wpu), .ext_val(we),
      .ext_en(xen), .pin(wp));
   iop_pin_model #(.W(4)) key_pins (.pclk(pclk), .dev_out(ko), .dev_oe(koe), .dev_pu(kpu), .ext_val(ke),
      .ext_en(xen[3:0]), .pin(kp));
   iop_io_port_bank iop_io_port_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_pin_port_in(sp), .serial_pin_port_out(so), .serial_pin_port_oe(soe), .serial_pin_port_pu(spu),
      .ext_irq_port_in(xi), .ext_irq_port_pu(xpu), .analog_in_port_in(ana), .comparator_inputs(cmp),
      .timer_pin_port_in(tp), .timer_pin_port_out(to), .timer_pin_port_oe(toe), .timer_pin_port_pu(tpu),
      .wide_port_in(wp), .wide_port_out(wo), .wide_port_oe(woe), .wide_port_pu(wpu), .key_tone_port_in(kp),
      .key_tone_port_out(ko), .key_tone_port_oe(koe), .key_tone_port_pu(kpu), .ext_irq_a(ia), .ext_irq_b(ib),
      .key_edge_quasi_irq(ik), .irq(irq));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // zero-wait slave, but the wait loop does not rely on it
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      integer n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) err_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask
   task end_sim;
      if (err_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (ib === 1'b1) nb <= nb + 1;
      if (cyc == 20000) begin
         err_count++;
         end_sim;
      end
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("oe_rst", 32'h0, {14'h0, soe, toe, koe, woe});
      for (i = 0; i < 11; i++) rchk("cfg_rst", IOP_ADDR_DIR_SER + 12'(i << 2), 32'h0);
      apb(1'b0, 12'h43C, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_rd", 32'h0, rd);
      apb(1'b1, IOP_ADDR_IRQ_EN, 32'h7);
      apb(1'b1, IOP_ADDR_IRQ_CLR, 32'h7);
      for (i = 0; i < 8; i++) begin
         apb(1'b1, IOP_ADDR_EDGE_SEL, {31'h0, tab[i][6]});
         xi <= tab[i][5:4];
         ke <= {3'h7, tab[i][3]};
         repeat (6) @(posedge pclk);
         rchk("status", IOP_ADDR_IRQ_STAT, {29'h0, tab[i][2:0]});
         chk("irq", {31'h0, tab[i][2:0] != 3'h0}, {31'h0, irq});
         apb(1'b1, IOP_ADDR_IRQ_CLR, 32'h7);
      end
      chk("irq_b_pulses", 32'h2, nb);
      apb(1'b1, IOP_ADDR_IRQ_EN, 32'h0);
      xi <= 2'h1;
      repeat (6) @(posedge pclk);
      chk("masked", 32'h0, {31'h0, irq});
      apb(1'b1, IOP_ADDR_IRQ_EN, 32'h1);
      repeat (2) @(posedge pclk);
      chk("unmasked", 32'h1, {31'h0, irq});
      apb(1'b1, IOP_ADDR_IRQ_CLR, 32'h1);
      repeat (2) @(posedge pclk);
      chk("cleared", 32'h0, {31'h0, irq});
      apb(1'b1, IOP_ADDR_PU_EXT, 32'h3);
      for (j = 0; j < 4; j++) begin
         ana <= 4'($random(seed));
         xi <= 2'($random(seed));
         apb(1'b1, IOP_ADDR_ANALOG, 32'hF);
         repeat (4) @(posedge pclk);
         rchk("analog", IOP_ADDR_ANALOG, {28'h0, ana});
         rchk("extport", IOP_ADDR_EXTIRQ, {30'h0, xi});
         chk("ext_pu", 32'h3, {30'h0, xpu});
         chk("cmp", {28'h0, ana}, {28'h0, cmp});
      end
      for (i = 0; i < 3; i++) for (j = 0; j < 4; j++) begin
         m = (i == 2) ? 32'hF : 32'h7;
         d = (j == 0) ? m : (j == 1) ? 32'h0 : $random(seed) & m;
         v = $random(seed);
         x = $random(seed);
         e = ($random(seed) | ~x) & m;
         xen <= x[7:0];
         if (i == 0) se <= e[2:0];
         else if (i == 1) te <= e[2:0];
         else ke <= e[3:0];
         apb(1'b1, pa[i], v);
         apb(1'b1, da[i], d);
         apb(1'b1, ua[i], m);
         repeat (4) @(posedge pclk);
         rchk("port", pa[i], (v & d & m) | (e & ~d));
         {po, poe, ppu} = (i == 0) ? {1'b0, so, 1'b0, soe, 1'b0, spu} : (i == 1) ? {1'b0, to, 1'b0, toe, 1'b0, tpu}
            : {ko, koe, kpu};
         chk("oe", d, {28'h0, poe});
         chk("pu", m & ~d, {28'h0, ppu});
         chk("out", v & d, {28'h0, po & poe});
      end
      for (j = 0; j < 4; j++) begin
         d = $random(seed) & 32'hFF;
         v = $random(seed) & 32'hFF;
         e = $random(seed) & 32'hFF;
         od = (j == 0) ? 32'h0 : $random(seed) & 32'hFF;
         we <= e[7:0];
         xen <= 8'hFF;
         if (j[0]) apb(1'b1, IOP_ADDR_WIDE_AB, v);
         else begin
            apb(1'b1, IOP_ADDR_WIDE_A, v & 32'hF);
            apb(1'b1, IOP_ADDR_WIDE_B, v >> 4);
         end
         apb(1'b1, IOP_ADDR_DIR_WIDE, d);
         apb(1'b1, IOP_ADDR_PU_WIDE, {30'h0, j[1:0]});
         apb(1'b1, IOP_ADDR_OD_WIDE, od);
         repeat (4) @(posedge pclk);
         x = (v & d) | (e & ~d);
         rchk("wide_ab", IOP_ADDR_WIDE_AB, x);
         rchk("wide_b", IOP_ADDR_WIDE_B, x >> 4);
         rchk("wide_a", IOP_ADDR_WIDE_A, x & 32'hF);
         chk("wide_oe", d & ~(od & v), {24'h0, woe});
         chk("wide_pu", {24'h0, {4{j[1]}}, {4{j[0]}}} & ~d, {24'h0, wpu});
      end
      end_sim;
   end
endmodule
